// [include/fhb_pkg.sv]
// shared constants, states and bus styles for the framer host bus handshake
`default_nettype none
package fhb_pkg;
   localparam int ADDR_W = 8; // register address width
   localparam int DATA_W = 8; // data bus width
   localparam logic [ADDR_W-1:0] INTERRUPT_POLARITY_INVERT_ADDR = 8'h06; // control register holding polarity bit
   localparam int INTERRUPT_POLARITY_INVERT_BIT = 4; // interrupt polarity invert bit position
   localparam int RESET_MIN_CYCLES = 10; // least reset length in core clocks
   localparam int LINE_GAP_MIN = 10; // least core edges between line clock rises
   localparam int CNT_W = 4; // width of the small counters
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0; // counter clear value
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1; // counter step
   localparam logic [CNT_W-1:0] RESET_LAST = 4'h9; // RESET_MIN_CYCLES - 1
   localparam logic [CNT_W-1:0] GAP_MIN_CNT = 4'ha; // LINE_GAP_MIN as counter value
   localparam logic [CNT_W-1:0] CNT_MAX = 4'hf; // counter saturation
   localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00; // data reset value
   localparam logic [DATA_W-1:0] BUS_PULL = 8'hff; // undriven data bus level
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00; // address reset value
   // bus style strap
   typedef enum logic {
      STYLE_STROBE = 1'b0, // separate read and write strobes, ready output
      STYLE_RWLINE = 1'b1  // single read/write line, acknowledge output
   } fhb_style_t;
   // device end transfer states, gray along idle, access, ack
   typedef enum logic [1:0] {
      DEV_IDLE = 2'h0,
      DEV_ACCESS = 2'h1,
      DEV_ACK = 2'h3
   } fhb_dev_state_t;
   // host end transfer states, gray along idle, wait, release
   typedef enum logic [1:0] {
      HST_IDLE = 2'h0,
      HST_WAIT = 2'h1,
      HST_RELEASE = 2'h3
   } fhb_hst_state_t;
endpackage
`default_nettype wire

// [include/fhb_if.sv]
// pin level interface between host processor and framer bus port
`timescale 1ns/1ps
`default_nettype none
interface fhb_if;
   logic sel_n; // select, low enables a transfer
   logic rd_n; // read strobe, or read/write line in single-line style
   logic wr_n; // write strobe, held high in single-line style
   logic [fhb_pkg::ADDR_W-1:0] addr; // register address
   logic [fhb_pkg::DATA_W-1:0] host_data; // host data drive value
   logic host_data_oe_n; // host drives data when low
   logic [fhb_pkg::DATA_W-1:0] dev_data; // device data drive value
   logic dev_data_oe_n; // device drives data when low
   logic [fhb_pkg::DATA_W-1:0] data_bus; // resolved data bus
   logic ack_out; // ready or acknowledge drive value
   logic ack_oe_n; // device drives ack when low
   logic ack_level; // resolved ack line, pulled high
   logic irq_out; // interrupt pin level
   logic reset_n; // device reset pin, low resets
   logic bus_style; // bus style strap
   // wire resolution with pull-ups
   assign data_bus = !host_data_oe_n ? host_data : (!dev_data_oe_n ? dev_data : fhb_pkg::BUS_PULL);
   assign ack_level = !ack_oe_n ? ack_out : 1'b1;
   modport dev (input sel_n, rd_n, wr_n, addr, data_bus, reset_n, bus_style,
      output dev_data, dev_data_oe_n, ack_out, ack_oe_n, irq_out);
   modport host (output sel_n, rd_n, wr_n, addr, host_data, host_data_oe_n, reset_n, bus_style,
      input data_bus, ack_level, irq_out);
endinterface
`default_nettype wire

// [hw/fhb_device_end.sv]
// framer end of the host bus: strobe decode, ready/acknowledge, interrupt pin, line clock sync
// Notes on behaviour
// RQ1: strobe style drives ready high when done
// RQ2: ready low while busy; host waits
// RQ3: single-line read acks low with data
// RQ4: single-line write acks low when accepted
// RQ5: acknowledge released to high impedance after low
// RQ6: strobe style interrupt active high by default
// RQ7: single-line style interrupt active low by default
// RQ8: polarity bit set inverts interrupt sense
// RQ9: low reset pin resets; held ten clocks
// RQ10: reset applied only after clocks stable
// RQ11: core clock runs state; line clock synchronised
// RQ12: ten core edges between line clock rises
// RQ13: host pulls select low for transfers
// RQ14: read/write line high read, low write
// RQ15: read or write strobe low per access
// RQ16: unused write strobe tied high
// RQ17: bus style is static strap for session
`timescale 1ns/1ps
`default_nettype none
module fhb_device_end (
   input wire logic core_clk,
   input wire logic rst,
   fhb_if.dev bus,
   output logic reg_req,
   output logic reg_we,
   output logic [fhb_pkg::ADDR_W-1:0] reg_addr,
   output logic [fhb_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_ready,
   input wire logic [fhb_pkg::DATA_W-1:0] reg_rdata,
   input wire logic irq_pending,
   output logic interrupt_polarity_invert,
   output logic bus_style_active,
   output logic in_reset,
   input wire logic line_receive_clock,
   output logic line_rise,
   output logic line_gap_error,
   input wire logic line_gap_clear
);
   logic dev_rst; // combined reset
   logic sel_act; // select asserted
   logic strobe_act; // a strobe asserted for this style
   logic is_read; // current access reads
   logic is_strobe; // strobe style active
   fhb_pkg::fhb_dev_state_t state_reg; // transfer state
   fhb_pkg::fhb_dev_state_t state_next;
   fhb_pkg::fhb_style_t style_reg; // latched bus style
   fhb_pkg::fhb_style_t style_next;
   logic [fhb_pkg::ADDR_W-1:0] addr_reg; // captured address
   logic [fhb_pkg::ADDR_W-1:0] addr_next;
   logic [fhb_pkg::DATA_W-1:0] wdata_reg; // captured write data
   logic [fhb_pkg::DATA_W-1:0] wdata_next;
   logic [fhb_pkg::DATA_W-1:0] rdata_reg; // read data held on the bus
   logic [fhb_pkg::DATA_W-1:0] rdata_next;
   logic we_reg; // access is a write
   logic we_next;
   logic pol_reg; // interrupt polarity invert bit
   logic pol_next;
   logic irq_reg; // interrupt pin level
   logic irq_next;
   logic sync1_reg; // line clock first sync stage
   logic sync2_reg; // line clock second sync stage
   logic sync3_reg; // delayed copy for edge detect
   logic sync1_next;
   logic sync2_next;
   logic sync3_next;
   logic [fhb_pkg::CNT_W-1:0] gap_cnt_reg; // core edges since last line rise
   logic [fhb_pkg::CNT_W-1:0] gap_cnt_next;
   logic seen_reg; // a first line rise was seen
   logic seen_next;
   logic gap_err_reg; // sticky short gap flag
   logic gap_err_next;
   logic rise; // line clock rising edge pulse

   // reset pin low acts as a synchronous reset
   assign dev_rst = rst | ~bus.reset_n; // see RQ9
   assign sel_act = ~bus.sel_n;
   assign is_strobe = (style_reg == fhb_pkg::STYLE_STROBE);
   // strobe style needs a strobe; single-line style uses select alone
   assign strobe_act = is_strobe ? (~bus.rd_n | ~bus.wr_n) : 1'b1; // see RQ15
   // read sense per style
   assign is_read = is_strobe ? ~bus.rd_n : bus.rd_n; // see RQ14

   // next values for transfer, style, polarity and interrupt
   always_comb begin
      state_next = state_reg;
      style_next = style_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      we_next = we_reg;
      pol_next = pol_reg;
      // polarity and default sense per style
      irq_next = irq_pending ^ pol_reg ^ (style_reg == fhb_pkg::STYLE_RWLINE); // see RQ6 see RQ7 see RQ8
      if (dev_rst) begin
         // strap taken only while in reset, then frozen
         style_next = fhb_fhb_style(bus.bus_style); // see RQ17
         state_next = fhb_pkg::DEV_IDLE;
         addr_next = fhb_pkg::ADDR_ZERO;
         wdata_next = fhb_pkg::DATA_ZERO;
         rdata_next = fhb_pkg::DATA_ZERO;
         we_next = 1'b0;
         pol_next = 1'b0;
         irq_next = (bus.bus_style == fhb_pkg::STYLE_RWLINE); // inactive level
      end else begin
         case (state_reg)
            fhb_pkg::DEV_IDLE: begin
               // new access: capture address and write data
               if (sel_act && strobe_act) begin // see RQ13
                  addr_next = bus.addr;
                  wdata_next = bus.data_bus;
                  we_next = ~is_read;
                  state_next = fhb_pkg::DEV_ACCESS;
               end
            end
            fhb_pkg::DEV_ACCESS: begin
               // wait for the location to complete
               if (!sel_act) begin
                  state_next = fhb_pkg::DEV_IDLE;
               end else if (reg_ready) begin
                  rdata_next = reg_rdata;
                  if (addr_reg == fhb_pkg::INTERRUPT_POLARITY_INVERT_ADDR) begin
                     rdata_next[fhb_pkg::INTERRUPT_POLARITY_INVERT_BIT] = pol_reg;
                     if (we_reg) begin
                        pol_next = wdata_reg[fhb_pkg::INTERRUPT_POLARITY_INVERT_BIT]; // see RQ8
                     end
                  end
                  state_next = fhb_pkg::DEV_ACK;
               end
            end
            fhb_pkg::DEV_ACK: begin
               // hold ack until host ends the cycle
               if (!sel_act || !strobe_act) begin
                  state_next = fhb_pkg::DEV_IDLE;
               end
            end
            default: begin
               state_next = fhb_pkg::DEV_IDLE;
            end
         endcase
      end
   end

   // bus style cast helper
   function automatic fhb_pkg::fhb_style_t fhb_fhb_style(input logic pin);
      fhb_fhb_style = pin ? fhb_pkg::STYLE_RWLINE : fhb_pkg::STYLE_STROBE;
   endfunction

   // register transfer, style, polarity and interrupt
   always_ff @(posedge core_clk) begin
      state_reg <= state_next;
      style_reg <= style_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      we_reg <= we_next;
      pol_reg <= pol_next;
      irq_reg <= irq_next;
   end

   // line clock sync and gap check next values
   always_comb begin
      sync1_next = line_receive_clock;
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
      gap_cnt_next = gap_cnt_reg;
      seen_next = seen_reg;
      gap_err_next = gap_err_reg;
      if (dev_rst) begin
         gap_cnt_next = fhb_pkg::CNT_ZERO;
         seen_next = 1'b0;
         gap_err_next = 1'b0;
      end else begin
         // clear first so a fresh error wins
         if (line_gap_clear) begin
            gap_err_next = 1'b0;
         end
         if (rise) begin
            if (seen_reg && (gap_cnt_reg < fhb_pkg::GAP_MIN_CNT)) begin
               gap_err_next = 1'b1; // see RQ12
            end
            seen_next = 1'b1;
            gap_cnt_next = fhb_pkg::CNT_ONE;
         end else if (gap_cnt_reg != fhb_pkg::CNT_MAX) begin
            gap_cnt_next = gap_cnt_reg + fhb_pkg::CNT_ONE;
         end
      end
   end

   // register line clock sync and gap check
   always_ff @(posedge core_clk) begin
      sync1_reg <= sync1_next; // see RQ11
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
      gap_cnt_reg <= gap_cnt_next;
      seen_reg <= seen_next;
      gap_err_reg <= gap_err_next;
   end

   // rise taken after second stage only
   assign rise = sync2_reg & ~sync3_reg; // see RQ11
   assign line_rise = rise;
   assign line_gap_error = gap_err_reg;

   // core side register request
   assign reg_req = (state_reg == fhb_pkg::DEV_ACCESS) & sel_act;
   assign reg_we = we_reg;
   assign reg_addr = addr_reg;
   assign reg_wdata = wdata_reg;
   assign interrupt_polarity_invert = pol_reg;
   assign bus_style_active = style_reg;
   assign in_reset = dev_rst;

   // ready or acknowledge pin per style
   always_comb begin
      bus.ack_out = 1'b0;
      bus.ack_oe_n = 1'b1;
      if (!dev_rst && sel_act) begin
         if (is_strobe) begin
            // ready low while busy, high once done
            bus.ack_oe_n = 1'b0;
            bus.ack_out = (state_reg == fhb_pkg::DEV_ACK); // see RQ1 see RQ2
         end else if (state_reg == fhb_pkg::DEV_ACK) begin
            // low ack for read data valid or write accepted, released with select
            bus.ack_oe_n = 1'b0; // see RQ3 see RQ4 see RQ5
            bus.ack_out = 1'b0;
         end
      end
   end

   // read data driven only while acked
   assign bus.dev_data = rdata_reg;
   assign bus.dev_data_oe_n = ~(~dev_rst & sel_act & (state_reg == fhb_pkg::DEV_ACK) & ~we_reg); // see RQ3
   assign bus.irq_out = irq_reg;
endmodule
`default_nettype wire

// [hw/fhb_host_end.sv]
// host processor end of the framer bus: cycle generation, wait states, reset pulse
`timescale 1ns/1ps
`default_nettype none
module fhb_host_end (
   input wire logic core_clk,
   input wire logic rst,
   fhb_if.host bus,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [fhb_pkg::ADDR_W-1:0] cmd_addr,
   input wire logic [fhb_pkg::DATA_W-1:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [fhb_pkg::DATA_W-1:0] rsp_rdata,
   input wire logic style_select,
   input wire logic clocks_stable,
   input wire logic reset_request,
   output logic device_in_reset,
   output logic irq_request
);
   fhb_pkg::fhb_hst_state_t state_reg; // cycle state
   fhb_pkg::fhb_hst_state_t state_next;
   logic [fhb_pkg::ADDR_W-1:0] addr_reg; // cycle address
   logic [fhb_pkg::ADDR_W-1:0] addr_next;
   logic [fhb_pkg::DATA_W-1:0] wdata_reg; // cycle write data
   logic [fhb_pkg::DATA_W-1:0] wdata_next;
   logic [fhb_pkg::DATA_W-1:0] rdata_reg; // captured read data
   logic [fhb_pkg::DATA_W-1:0] rdata_next;
   logic write_reg; // cycle is a write
   logic write_next;
   logic rsp_reg; // response pulse
   logic rsp_next;
   logic pol_reg; // tracked polarity bit
   logic pol_next;
   logic irq_reg; // decoded interrupt request
   logic irq_next;
   logic style_reg; // strap driven to device
   logic style_next;
   logic pend_reg; // reset waiting for stable clocks
   logic pend_next;
   logic active_reg; // reset pin held low
   logic active_next;
   logic [fhb_pkg::CNT_W-1:0] cnt_reg; // reset length counter
   logic [fhb_pkg::CNT_W-1:0] cnt_next;
   logic done; // device ended wait states
   logic is_rw; // single-line style

   assign is_rw = (style_reg == fhb_pkg::STYLE_RWLINE);
   // completion sense per style
   assign done = is_rw ? ~bus.ack_level : bus.ack_level; // see RQ2

   // next values for cycle, reset pulse and interrupt decode
   always_comb begin
      state_next = state_reg;
      addr_next = addr_reg;
      wdata_next = wdata_reg;
      rdata_next = rdata_reg;
      write_next = write_reg;
      rsp_next = 1'b0;
      pol_next = pol_reg;
      irq_next = bus.irq_out ^ pol_reg ^ is_rw;
      style_next = style_reg;
      pend_next = pend_reg | reset_request;
      active_next = active_reg;
      cnt_next = cnt_reg;
      if (rst) begin
         state_next = fhb_pkg::HST_IDLE;
         addr_next = fhb_pkg::ADDR_ZERO;
         wdata_next = fhb_pkg::DATA_ZERO;
         rdata_next = fhb_pkg::DATA_ZERO;
         write_next = 1'b0;
         pol_next = 1'b0;
         irq_next = 1'b0;
         style_next = 1'b0;
         pend_next = 1'b1;
         active_next = 1'b0;
         cnt_next = fhb_pkg::CNT_ZERO;
      end else begin
         // reset pulse: start only with stable clocks, hold ten clocks
         if (active_reg) begin
            style_next = style_select;
            cnt_next = cnt_reg + fhb_pkg::CNT_ONE;
            if (cnt_reg == fhb_pkg::RESET_LAST) begin
               active_next = 1'b0; // see RQ9
            end
         end else if (pend_reg && clocks_stable && (state_reg == fhb_pkg::HST_IDLE)) begin
            active_next = 1'b1; // see RQ10
            pend_next = reset_request;
            cnt_next = fhb_pkg::CNT_ZERO;
            style_next = style_select;
            pol_next = 1'b0;
         end
         case (state_reg)
            fhb_pkg::HST_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  addr_next = cmd_addr;
                  wdata_next = cmd_wdata;
                  write_next = cmd_write;
                  state_next = fhb_pkg::HST_WAIT;
               end
            end
            fhb_pkg::HST_WAIT: begin
               // wait states until ready or acknowledge
               if (done) begin // see RQ2
                  if (!write_reg) begin
                     rdata_next = bus.data_bus;
                  end else if (addr_reg == fhb_pkg::INTERRUPT_POLARITY_INVERT_ADDR) begin
                     pol_next = wdata_reg[fhb_pkg::INTERRUPT_POLARITY_INVERT_BIT];
                  end
                  rsp_next = 1'b1;
                  state_next = fhb_pkg::HST_RELEASE;
               end
            end
            fhb_pkg::HST_RELEASE: begin
               // release then idle: at least two idle bus cycles between transfers
               state_next = fhb_pkg::HST_IDLE;
            end
            default: begin
               state_next = fhb_pkg::HST_IDLE;
            end
         endcase
      end
   end

   // register cycle, reset pulse and interrupt decode
   always_ff @(posedge core_clk) begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      rsp_reg <= rsp_next;
      pol_reg <= pol_next;
      irq_reg <= irq_next;
      style_reg <= style_next;
      pend_reg <= pend_next;
      active_reg <= active_next;
      cnt_reg <= cnt_next;
   end

   // bus pins per style
   always_comb begin
      bus.sel_n = ~(state_reg == fhb_pkg::HST_WAIT); // see RQ13
      if (is_rw) begin
         bus.rd_n = ~((state_reg == fhb_pkg::HST_WAIT) & write_reg); // see RQ14
         bus.wr_n = 1'b1; // see RQ16
      end else begin
         bus.rd_n = ~((state_reg == fhb_pkg::HST_WAIT) & ~write_reg); // see RQ15
         bus.wr_n = ~((state_reg == fhb_pkg::HST_WAIT) & write_reg);
      end
   end

   assign bus.addr = addr_reg;
   assign bus.host_data = wdata_reg;
   assign bus.host_data_oe_n = ~((state_reg == fhb_pkg::HST_WAIT) & write_reg);
   assign bus.reset_n = ~active_reg;
   assign bus.bus_style = style_reg;
   assign cmd_ready = (state_reg == fhb_pkg::HST_IDLE) & ~active_reg & ~pend_reg & ~rst;
   assign rsp_valid = rsp_reg;
   assign rsp_rdata = rdata_reg;
   assign device_in_reset = active_reg;
   assign irq_request = irq_reg;
endmodule
`default_nettype wire

// [verif/fhb_checker.sv]
// pin-level assertions watching the host bus between the two ends
`timescale 1ns/1ps
`default_nettype none
module fhb_checker (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sel_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic dev_data_oe_n,
   input wire logic ack_out,
   input wire logic ack_oe_n,
   input wire logic irq_out,
   input wire logic reset_n,
   input wire logic bus_style
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // reset pin held low for exactly ten edges
   sequence s_pulse_low;
      !reset_n [*8] ##1 !reset_n ##1 !reset_n;
   endsequence
   // select idle for two samples in a row
   sequence s_sel_idle;
      sel_n ##1 sel_n;
   endsequence
   AST_RESET_TEN: assert property ($fell(reset_n) |-> s_pulse_low ##1 reset_n)
      else $error("reset pin pulse length wrong");
   AST_RESET_IRQ_IDLE: assert property (!reset_n ##1 !reset_n |-> irq_out == bus_style)
      else $error("interrupt pin not inactive in reset");
   AST_STROBE_READY: assert property (!bus_style && !sel_n && !rd_n && !ack_oe_n && ack_out |-> !dev_data_oe_n)
      else $error("ready high without read data");
   AST_STROBE_WAIT: assert property (!bus_style && !ack_oe_n && !ack_out |-> dev_data_oe_n)
      else $error("data driven while ready low");
   AST_RW_READ_ACK: assert property (bus_style && rd_n && !sel_n && !ack_oe_n |-> !ack_out && !dev_data_oe_n)
      else $error("read acknowledge without low level and data");
   AST_RW_WRITE_ACK: assert property (bus_style && !rd_n && !sel_n && !ack_oe_n |-> !ack_out && dev_data_oe_n)
      else $error("write acknowledge wrong");
   AST_ACK_RELEASE: assert property (s_sel_idle |-> ack_oe_n && dev_data_oe_n)
      else $error("acknowledge or data still driven while idle");
   AST_STRAP_STATIC: assert property (reset_n && $past(reset_n) |-> $stable(bus_style))
      else $error("bus style changed outside reset");
   AST_RW_WR_HIGH: assert property (bus_style && reset_n |-> wr_n)
      else $error("write strobe low in single line style");
   AST_ONE_STROBE: assert property (!bus_style |-> rd_n || wr_n)
      else $error("both strobes low");
endmodule
`default_nettype wire

// [verif/tb.sv]
// self-checking bench joining host end and framer end over the pin interface
`timescale 1ns/1ps
`default_nettype none
module tb;
   // one bus transfer: style, write, address, data, core stalls, interrupt input
   typedef struct packed {
      logic style; logic we; logic [7:0] addr; logic [7:0] wdata; logic [3:0] waits; logic irq;
   } fhb_row_t;
   localparam int NUM_ROWS = 9; // table length
   fhb_row_t rows [NUM_ROWS] = '{
      {1'b0, 1'b1, 8'h10, 8'ha5, 4'h0, 1'b1}, {1'b0, 1'b0, 8'h10, 8'h00, 4'h2, 1'b0},
      {1'b0, 1'b1, 8'h06, 8'h10, 4'h0, 1'b0}, {1'b0, 1'b0, 8'h06, 8'h00, 4'h1, 1'b1},
      {1'b1, 1'b1, 8'h20, 8'h3c, 4'h1, 1'b1}, {1'b1, 1'b0, 8'h20, 8'h00, 4'h0, 1'b0},
      {1'b1, 1'b0, 8'h06, 8'h00, 4'h0, 1'b0}, {1'b1, 1'b1, 8'h06, 8'h10, 4'h0, 1'b1},
      {1'b1, 1'b0, 8'h10, 8'h00, 4'h3, 1'b0}};
   logic core_clk, rst, cmd_valid, cmd_write, cmd_ready, rsp_valid, style_select, clocks_stable;
   logic reset_request, device_in_reset, irq_request, reg_req, reg_we, reg_ready, irq_pending;
   logic interrupt_polarity_invert, bus_style_active, in_reset, line_receive_clock, line_rise;
   logic line_gap_error, line_gap_clear, cur_style, inv, exp_pin;
   logic [7:0] cmd_addr, cmd_wdata, rsp_rdata, reg_addr, reg_wdata, reg_rdata, got, exp;
   logic [7:0] core_mem [0:255]; // core storage behind the device end
   logic [7:0] shadow [0:255]; // expected register contents
   int mismatches = 0, num_checks = 0, cur_waits = 0, stall_cnt = 0, rise_cnt = 0, n;
   fhb_row_t row;
   fhb_if bus_if ();
   fhb_host_end fhb_host_end_inst (.core_clk(core_clk), .rst(rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .style_select(style_select), .clocks_stable(clocks_stable),
      .reset_request(reset_request), .device_in_reset(device_in_reset), .irq_request(irq_request));
   fhb_device_end fhb_device_end_inst (.core_clk(core_clk), .rst(rst), .bus(bus_if.dev), .reg_req(reg_req),
      .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ready(reg_ready), .reg_rdata(reg_rdata),
      .irq_pending(irq_pending), .interrupt_polarity_invert(interrupt_polarity_invert),
      .bus_style_active(bus_style_active), .in_reset(in_reset), .line_receive_clock(line_receive_clock),
      .line_rise(line_rise), .line_gap_error(line_gap_error), .line_gap_clear(line_gap_clear));
   fhb_checker fhb_checker_inst (.core_clk(core_clk), .rst(rst), .sel_n(bus_if.sel_n), .rd_n(bus_if.rd_n),
      .wr_n(bus_if.wr_n), .dev_data_oe_n(bus_if.dev_data_oe_n), .ack_out(bus_if.ack_out),
      .ack_oe_n(bus_if.ack_oe_n), .irq_out(bus_if.irq_out), .reset_n(bus_if.reset_n),
      .bus_style(bus_if.bus_style));
   assign reg_rdata = core_mem[reg_addr]; // core answers in the same cycle
   // clock generator
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   // core storage write and line pulse counter
   always @(posedge core_clk) begin
      if (reg_req === 1'b1 && reg_ready === 1'b1 && reg_we === 1'b1) core_mem[reg_addr] <= reg_wdata;
      if (line_rise === 1'b1) rise_cnt <= rise_cnt + 1;
   end
   // core ready after chosen stalls
   always @(negedge core_clk) begin
      if (reg_req === 1'b1) begin
         reg_ready <= (stall_cnt >= cur_waits);
         stall_cnt <= stall_cnt + 1;
      end else begin
         reg_ready <= 1'b0;
         stall_cnt <= 0;
      end
   end
   // compare and count
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask
   // one host command, select and answer cycles counted
   task automatic do_cmd(input logic we, input logic [7:0] a, input logic [7:0] d, input int w);
      int sel_cnt, ack_cnt;
      sel_cnt = 0;
      ack_cnt = 0;
      cur_waits = w;
      cmd_valid = 1'b1;
      cmd_write = we;
      cmd_addr = a;
      cmd_wdata = d;
      n = 0;
      while (cmd_ready !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
      @(negedge core_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 100) begin
         if (bus_if.sel_n === 1'b0) sel_cnt++;
         if (bus_if.sel_n === 1'b0 && bus_if.ack_level === ~cur_style) ack_cnt++;
         @(negedge core_clk);
         n++;
      end
      got = rsp_rdata;
      check("response", 8'h01, {7'h00, rsp_valid});
      check("select cycles", 8'(3 + w), 8'(sel_cnt));
      check("answer cycles", 8'h01, 8'(ack_cnt));
   endtask
   // reset pin pulse from the host end, length measured
   task automatic pulse_reset(input logic style, input logic by_req);
      int len;
      style_select = style;
      clocks_stable = 1'b1;
      reset_request = by_req;
      @(negedge core_clk);
      reset_request = 1'b0;
      n = 0;
      while (device_in_reset !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
      check("device in reset", 8'h01, {7'h00, in_reset});
      len = 0;
      while (device_in_reset === 1'b1 && len < 100) begin @(negedge core_clk); len++; end
      check("reset pin cycles", 8'h0a, 8'(len));
      check("strap", {7'h00, style}, {7'h00, bus_style_active});
      check("polarity cleared", 8'h00, {7'h00, interrupt_polarity_invert});
      inv = 1'b0;
      cur_style = style;
   endtask
   // line clock with a given spacing of rises
   task automatic line_edges(input int gap, input int cnt);
      repeat (cnt) begin
         repeat (gap / 2) @(negedge core_clk);
         line_receive_clock = 1'b1;
         repeat (gap - gap / 2) @(negedge core_clk);
         line_receive_clock = 1'b0;
      end
      repeat (5) @(negedge core_clk);
   endtask
   // verdict
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog
   initial begin
      #(40 * 5000);
      mismatches++;
      test_done();
   end
   // main sequence
   initial begin
      rst = 1'b1; cmd_valid = 1'b0; cmd_write = 1'b0; cmd_addr = 8'h00; cmd_wdata = 8'h00;
      style_select = 1'b0; clocks_stable = 1'b0; reset_request = 1'b0;
      irq_pending = 1'b0; line_receive_clock = 1'b0; line_gap_clear = 1'b0; cur_style = 1'b0; inv = 1'b0;
      repeat (12) @(negedge core_clk);
      rst = 1'b0;
      repeat (8) @(negedge core_clk);
      check("early reset pin", 8'h00, {7'h00, device_in_reset});
      pulse_reset(1'b0, 1'b0);
      for (int i = 0; i < NUM_ROWS; i++) begin
         row = rows[i];
         if (row.style !== cur_style) begin
            irq_pending = 1'b0;
            pulse_reset(row.style, 1'b1);
         end
         do_cmd(row.we, row.addr, row.wdata, int'(row.waits));
         if (row.we) begin
            shadow[row.addr] = row.wdata;
            if (row.addr == fhb_pkg::INTERRUPT_POLARITY_INVERT_ADDR) inv = row.wdata[fhb_pkg::INTERRUPT_POLARITY_INVERT_BIT];
         end else begin
            exp = shadow[row.addr];
            if (row.addr == fhb_pkg::INTERRUPT_POLARITY_INVERT_ADDR) exp[fhb_pkg::INTERRUPT_POLARITY_INVERT_BIT] = inv;
            check("read data", exp, got);
         end
         check("polarity", {7'h00, inv}, {7'h00, interrupt_polarity_invert});
         irq_pending = row.irq;
         exp_pin = row.irq ^ inv ^ row.style;
         n = 0;
         while ((bus_if.irq_out !== exp_pin || irq_request !== row.irq) && n < 6) begin
            @(negedge core_clk);
            n++;
         end
         check("interrupt pin", {7'h00, exp_pin}, {7'h00, bus_if.irq_out});
         check("host interrupt", {7'h00, row.irq}, {7'h00, irq_request});
      end
      line_edges(10, 4);
      check("line rises", 8'h04, 8'(rise_cnt));
      check("gap ok", 8'h00, {7'h00, line_gap_error});
      line_edges(9, 2);
      check("gap short", 8'h01, {7'h00, line_gap_error});
      line_gap_clear = 1'b1;
      @(negedge core_clk);
      line_gap_clear = 1'b0;
      @(negedge core_clk);
      check("gap cleared", 8'h00, {7'h00, line_gap_error});
      rst = 1'b1;
      clocks_stable = 1'b0;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      repeat (8) @(negedge core_clk);
      check("unstable reset pin", 8'h00, {7'h00, device_in_reset});
      pulse_reset(cur_style, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
